// ---- logic/plpic_pkg.sv ----
// constants and types for the pcs low power idle control block
//
// Notes on behaviour
// - after lpi block sent, quiet at next payload
// - refresh sub-blocks sent at normal slot times
// - payload slot starts with 130 zero symbols
// - then 7644 symbols with transmitter off
// - then 130 zeros before refresh sub-blocks
// - repeat until normal interframe, resume at payload
// - slot timing keeps running through quiet periods
// - sleep is zeros, wake is precoded signal
// - zeros at payload start put receiver in lpi
// - received lpi blocks also show lpi on gmii
// - refresh drives adaptation, timing, receiver status
// - refresh used to estimate link margin
// - signal at payload start ends receive lpi
// - decoding restarts at first complete block boundary
// - normal interframe presented once decoding restarts
// - transmit gate on in refresh, off in quiet
// - receive gate on in refresh, off in quiet
package plpic_pkg;
  localparam int unsigned IDX_W        = 13;
  localparam int unsigned SYM_W        = 8;
  localparam int unsigned ZERO_SYMS    = 130;
  localparam int unsigned QUIET_SYMS   = 7644;
  localparam int unsigned REFRESH_SYMS = 160;
  localparam int unsigned ZDET_WIN     = 32;
  localparam int unsigned ZDET_MIN     = 24;
  localparam logic [SYM_W-1:0] ZERO_SYM = 8'h00;
  // register map
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_COUNT  = 12'h008;
  localparam logic        CTRL_RST   = 1'h0;
  localparam int unsigned CTRL_EEE   = 0;
  localparam int unsigned ST_TX_LPI  = 0;
  localparam int unsigned ST_TX_QT   = 1;
  localparam int unsigned ST_RX_LPI  = 2;
  localparam int unsigned ST_RX_QT   = 3;
  localparam int unsigned CNT_TX_LSB = 0;
  localparam int unsigned CNT_RX_LSB = 16;
  typedef enum logic [1:0] {TX_NORMAL, TX_ARMED, TX_LPI} plpic_tx_e;
  typedef enum logic [1:0] {RX_NORMAL, RX_LPI, RX_WAKE} plpic_rx_e;
endpackage

// ---- logic/plpic_slot_if.sv ----
// slot timing shared by the timer and its users
`timescale 1ns/1ps
`default_nettype none
interface plpic_slot_if;
  logic [12:0] idx;
  logic        in_payload;
  logic        payload_start;
  logic        refresh_end;
  modport timer (output idx, output in_payload, output payload_start, output refresh_end);
  modport user  (input idx, input in_payload, input payload_start, input refresh_end);
endinterface
`default_nettype wire

// ---- logic/plpic_slot_timer.sv ----
// free running refresh/payload sub-block slot timer
`timescale 1ns/1ps
`default_nettype none
module plpic_slot_timer #(
  parameter int unsigned QUIET = 7644
) (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // realign to the start of a refresh sub-block
  input  wire logic  sync,
  // slot timing
  plpic_slot_if.timer slot
);
  import plpic_pkg::*;
  localparam logic [IDX_W-1:0] REF_LAST = IDX_W'(REFRESH_SYMS - 1);
  localparam logic [IDX_W-1:0] PAY_LAST = IDX_W'(2 * ZERO_SYMS + QUIET - 1);
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic             in_payload;
  } plpic_tm_s;
  plpic_tm_s s, next_s;

  // never stops, so block alignment survives quiet periods
  always_comb begin
    next_s = s;
    if (sync) begin
      next_s = '0;
    end else if (!s.in_payload && s.idx == REF_LAST) begin
      next_s.idx        = '0;
      next_s.in_payload = 1'b1;
    end else if (s.in_payload && s.idx == PAY_LAST) begin
      next_s = '0;
    end else begin
      next_s.idx = s.idx + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else          s <= next_s;
  end

  assign slot.idx           = s.idx;
  assign slot.in_payload    = s.in_payload;
  assign slot.payload_start = s.in_payload && s.idx == '0;
  assign slot.refresh_end   = !s.in_payload && s.idx == REF_LAST;
endmodule // plpic_slot_timer
`default_nettype wire

// ---- logic/plpic_zero_detect.sv ----
// decides zeros or precoded signal at the start of each payload slot
`timescale 1ns/1ps
`default_nettype none
module plpic_zero_detect (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // receive slot timing and symbols
  plpic_slot_if.user                  slot,
  input  wire logic [plpic_pkg::SYM_W-1:0] rx_sym,
  // decisions, one cycle pulses
  output logic                        zero_seen,
  output logic                        sig_seen
);
  import plpic_pkg::*;
  localparam logic [IDX_W-1:0] WIN_LAST = IDX_W'(ZDET_WIN - 1);
  localparam logic [5:0]       RUN_MIN  = 6'(ZDET_MIN);
  typedef struct packed {
    logic [5:0] zcnt;
    logic       zero_seen;
    logic       sig_seen;
  } plpic_zd_s;
  plpic_zd_s s, next_s;
  logic [5:0] cnt_now;

  // 24 or more zeros in the first 32 payload symbols mean sleep, fewer mean wake
  always_comb begin
    next_s  = s;
    cnt_now = (slot.idx == '0 ? 6'h00 : s.zcnt) + 6'(rx_sym == ZERO_SYM);
    next_s.zero_seen = 1'b0;
    next_s.sig_seen  = 1'b0;
    if (slot.in_payload && slot.idx <= WIN_LAST) begin
      next_s.zcnt = cnt_now;
      if (slot.idx == WIN_LAST) begin
        next_s.zero_seen = cnt_now >= RUN_MIN;
        next_s.sig_seen  = cnt_now < RUN_MIN;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else          s <= next_s;
  end

  assign zero_seen = s.zero_seen;
  assign sig_seen  = s.sig_seen;
endmodule // plpic_zero_detect
`default_nettype wire

// ---- logic/plpic_lpi_ctrl.sv ----
// low power idle transmit and receive control with apb registers
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module plpic_lpi_ctrl #(
  parameter int unsigned QUIET = plpic_pkg::QUIET_SYMS
) (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // gmii transmit side and block encoder
  input  wire logic                        tx_lpi_req,
  input  wire logic                        enc_blk_end,
  input  wire logic                        enc_blk_lpi,
  input  wire logic [plpic_pkg::SYM_W-1:0] tx_sym_in,
  // transmit symbols and gate towards the pmd
  output logic [plpic_pkg::SYM_W-1:0]      tx_sym_out,
  output logic                             tx_pcs_on,
  // receive symbols and slot sync from the pma
  input  wire logic [plpic_pkg::SYM_W-1:0] rx_sym,
  input  wire logic                        rx_frame_sync,
  // block decoder
  input  wire logic                        rx_blk_start,
  input  wire logic                        rx_blk_lpi,
  // gmii receive side and receiver control
  output logic                             rx_lpi,
  output logic                             rx_dec_en,
  output logic                             rx_pcs_on,
  output logic                             rx_adapt_en,
  output logic                             rx_margin_en,
  output logic                             rx_status_upd
);
  import plpic_pkg::*;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] QT_START = IDX_W'(ZERO_SYMS);
  localparam logic [IDX_W-1:0] QT_END   = IDX_W'(ZERO_SYMS + QUIET);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    plpic_tx_e        tx_st;
    logic             tx_wake;
    logic             tx_quiet;
    logic [15:0]      tx_cnt;
    logic [SYM_W-1:0] tx_sym_out;
    logic             tx_pcs_on;
    plpic_rx_e        rx_st;
    logic             rx_quiet;
    logic [15:0]      rx_cnt;
    logic             rx_lpi;
    logic             rx_dec_en;
    logic             rx_pcs_on;
    logic             rx_adapt_en;
    logic             rx_margin_en;
    logic             rx_status_upd;
    logic             eee_en;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } plpic_top_s;

  plpic_top_s s;
  plpic_top_s next_s;

  // ----------------------------------------------------------------
  // slot timers and zero detector
  // ----------------------------------------------------------------
  plpic_slot_if tx_slot ();
  plpic_slot_if rx_slot ();

  logic zero_seen;
  logic sig_seen;

  plpic_slot_timer #(
    .QUIET (QUIET)
  ) u_tx_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .sync    (1'b0),
    .slot    (tx_slot.timer)
  );

  plpic_slot_timer #(
    .QUIET (QUIET)
  ) u_rx_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .sync    (rx_frame_sync),
    .slot    (rx_slot.timer)
  );

  plpic_zero_detect u_zdet (
    .pclk      (pclk),
    .presetn   (presetn),
    .slot      (rx_slot.user),
    .rx_sym    (rx_sym),
    .zero_seen (zero_seen),
    .sig_seen  (sig_seen)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        tx_in_lpi;
  logic        rx_in_lpi;
  logic        rx_quiet_win;
  logic        tx_quiet_win;
  logic        apb_setup;
  logic        apb_write;
  logic        addr_ok;
  logic [31:0] rd_val;

  always_comb begin
    next_s = s;

    // ---------------- transmit control ----------------
    unique case (s.tx_st)
      TX_NORMAL: begin
        if (s.eee_en && tx_lpi_req && enc_blk_end && enc_blk_lpi) begin
          next_s.tx_st = TX_ARMED;
        end
      end
      TX_ARMED: begin
        if (!tx_lpi_req) begin
          next_s.tx_st = TX_NORMAL;
        end else if (tx_slot.payload_start) begin
          next_s.tx_st  = TX_LPI;
          next_s.tx_cnt = s.tx_cnt + 16'h0001;
        end
      end
      TX_LPI: begin
        if (!tx_lpi_req) begin
          next_s.tx_wake = 1'b1;
        end
        if (tx_slot.payload_start && (s.tx_wake || !tx_lpi_req)) begin
          next_s.tx_st   = TX_NORMAL;
          next_s.tx_wake = 1'b0;
        end
      end
    endcase

    // symbol sequence inside a payload slot
    tx_in_lpi    = next_s.tx_st == TX_LPI && tx_slot.in_payload;
    tx_quiet_win = tx_slot.idx >= QT_START && tx_slot.idx < QT_END;
    next_s.tx_quiet = tx_in_lpi && tx_quiet_win;
    if (!tx_in_lpi) begin
      // refresh slots always carry the encoder output
      next_s.tx_sym_out = tx_sym_in;
      next_s.tx_pcs_on  = 1'b1;
    end else if (tx_quiet_win) begin
      next_s.tx_sym_out = ZERO_SYM;
      next_s.tx_pcs_on  = 1'b0;
    end else begin
      // entry zeros then preparation zeros
      next_s.tx_sym_out = ZERO_SYM;
      next_s.tx_pcs_on  = 1'b1;
    end

    // ---------------- receive control ----------------
    unique case (s.rx_st)
      RX_NORMAL: begin
        if (zero_seen) begin
          next_s.rx_st  = RX_LPI;
          next_s.rx_cnt = s.rx_cnt + 16'h0001;
        end
      end
      RX_LPI: begin
        if (sig_seen) begin
          next_s.rx_st = RX_WAKE;
        end
      end
      RX_WAKE: begin
        if (rx_blk_start) begin
          next_s.rx_st = RX_NORMAL;
        end
      end
    endcase

    rx_in_lpi    = next_s.rx_st == RX_LPI;
    rx_quiet_win = rx_slot.in_payload && rx_slot.idx >= QT_START
                   && rx_slot.idx < QT_END;
    next_s.rx_quiet  = rx_in_lpi && rx_quiet_win;
    next_s.rx_pcs_on = !(rx_in_lpi && rx_quiet_win);
    // decoding and normal interframe return together
    next_s.rx_dec_en = next_s.rx_st == RX_NORMAL;
    next_s.rx_lpi    = next_s.rx_st != RX_NORMAL || rx_blk_lpi;
    next_s.rx_adapt_en  = rx_in_lpi && !rx_slot.in_payload;
    next_s.rx_margin_en = rx_in_lpi && !rx_slot.in_payload;
    next_s.rx_status_upd = s.rx_st == RX_LPI && rx_slot.refresh_end;

    // ---------------- apb slave ----------------
    apb_setup = psel && !penable;
    apb_write = psel && penable && s.pready && pwrite;
    addr_ok   = paddr == OFF_CTRL || paddr == OFF_STATUS || paddr == OFF_COUNT;
    rd_val    = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL: begin
        rd_val[CTRL_EEE] = s.eee_en;
      end
      OFF_STATUS: begin
        rd_val[ST_TX_LPI] = s.tx_st == TX_LPI;
        rd_val[ST_TX_QT]  = s.tx_quiet;
        rd_val[ST_RX_LPI] = s.rx_st != RX_NORMAL;
        rd_val[ST_RX_QT]  = s.rx_quiet;
      end
      OFF_COUNT: begin
        rd_val[CNT_TX_LSB +: 16] = s.tx_cnt;
        rd_val[CNT_RX_LSB +: 16] = s.rx_cnt;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
    // answer in the first access cycle, then drop
    next_s.pready  = apb_setup;
    next_s.pslverr = apb_setup && !addr_ok;
    if (apb_setup) begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end
    if (apb_write && paddr == OFF_CTRL) begin
      next_s.eee_en = pwdata[CTRL_EEE];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.tx_st     <= TX_NORMAL;
      s.rx_st     <= RX_NORMAL;
      s.eee_en    <= CTRL_RST;
      s.tx_pcs_on <= 1'b1;
      s.rx_pcs_on <= 1'b1;
      s.rx_dec_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign tx_sym_out    = s.tx_sym_out;
  assign tx_pcs_on     = s.tx_pcs_on;
  assign rx_lpi        = s.rx_lpi;
  assign rx_dec_en     = s.rx_dec_en;
  assign rx_pcs_on     = s.rx_pcs_on;
  assign rx_adapt_en   = s.rx_adapt_en;
  assign rx_margin_en  = s.rx_margin_en;
  assign rx_status_upd = s.rx_status_upd;
endmodule // plpic_lpi_ctrl
`default_nettype wire

// ---- sim/plpic_lpi_ctrl_assertions.sv ----
// checker for the pcs low power idle control block
`timescale 1ns/1ps
`default_nettype none
module plpic_lpi_ctrl_assertions #(parameter int unsigned QUIET = 7644) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // transmit
  input wire logic [plpic_pkg::SYM_W-1:0] tx_sym_out,
  input wire logic tx_pcs_on,
  // receive
  input wire logic rx_blk_start,
  input wire logic rx_blk_lpi,
  input wire logic rx_lpi,
  input wire logic rx_dec_en,
  input wire logic rx_pcs_on,
  input wire logic rx_adapt_en,
  input wire logic rx_margin_en,
  input wire logic rx_status_upd
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned tq;
  int unsigned rq;
  // length of the current quiet stretch of each gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq <= 0;
      rq <= 0;
    end else begin
      tq <= tx_pcs_on ? 0 : tq + 1;
      rq <= rx_pcs_on ? 0 : rq + 1;
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_zeros; (tx_sym_out == plpic_pkg::ZERO_SYM) [*4]; endsequence
  property p_apb_ready; s_setup |=> pready; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no pready after setup");
  property p_apb_err; pslverr |-> pready; endproperty
  a_apb_err: assert property (p_apb_err) else $error("pslverr without pready");
  property p_tx_quiet; $rose(tx_pcs_on) |-> tq == QUIET; endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("tx quiet length");
  property p_tx_quiet_max; tq <= QUIET; endproperty
  a_tx_quiet_max: assert property (p_tx_quiet_max) else $error("tx quiet too long");
  property p_tx_entry; $fell(tx_pcs_on) |-> $past(tx_sym_out) == 8'h00; endproperty
  a_tx_entry: assert property (p_tx_entry) else $error("no zeros before quiet");
  property p_tx_prep; $rose(tx_pcs_on) |-> s_zeros; endproperty
  a_tx_prep: assert property (p_tx_prep) else $error("no zeros after quiet");
  property p_tx_dark; !tx_pcs_on |-> tx_sym_out == 8'h00; endproperty
  a_tx_dark: assert property (p_tx_dark) else $error("symbols while quiet");
  property p_rx_quiet; $rose(rx_pcs_on) |-> rq == QUIET; endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("rx quiet length");
  property p_rx_gate; !rx_pcs_on |-> rx_lpi && !rx_dec_en; endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx quiet outside lpi");
  property p_rx_refresh; rx_adapt_en |-> rx_margin_en && rx_lpi && rx_pcs_on; endproperty
  a_rx_refresh: assert property (p_rx_refresh) else $error("refresh use wrong");
  property p_rx_blk_lpi; rx_blk_lpi |-> ##[0:1] rx_lpi; endproperty
  a_rx_blk_lpi: assert property (p_rx_blk_lpi) else $error("block lpi not shown");
  property p_rx_resume; $rose(rx_dec_en) |-> $past(rx_blk_start); endproperty
  a_rx_resume: assert property (p_rx_resume) else $error("decode off boundary");
  property p_rx_status; rx_status_upd |-> $past(rx_adapt_en) && rx_lpi; endproperty
  a_rx_status: assert property (p_rx_status) else $error("status update stray");
endmodule // plpic_lpi_ctrl_assertions
bind plpic_lpi_ctrl plpic_lpi_ctrl_assertions #(.QUIET(QUIET)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .tx_sym_out(tx_sym_out), .tx_pcs_on(tx_pcs_on), .rx_blk_start(rx_blk_start),
  .rx_blk_lpi(rx_blk_lpi), .rx_lpi(rx_lpi), .rx_dec_en(rx_dec_en), .rx_pcs_on(rx_pcs_on),
  .rx_adapt_en(rx_adapt_en), .rx_margin_en(rx_margin_en), .rx_status_upd(rx_status_upd));
`default_nettype wire

// ---- sim/plpic_link_partner.sv ----
// remote phy model: slot timed receive symbols and slot sync
`timescale 1ns/1ps
`default_nettype none
module plpic_link_partner import plpic_pkg::*; #(parameter int unsigned QUIET = 7644) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // low power idle request of the remote side
  input wire logic sleep,
  // line side
  output logic [SYM_W-1:0] rx_sym,
  output logic rx_frame_sync
);
  localparam int unsigned SLOT = REFRESH_SYMS + 2 * ZERO_SYMS + QUIET;
  int unsigned cnt;
  int unsigned pidx;
  logic slp;
  // request only taken at payload boundaries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      slp <= 1'b0;
    end else begin
      cnt <= (cnt == SLOT - 1) ? 0 : cnt + 1;
      if (cnt == REFRESH_SYMS - 1) slp <= sleep;
    end
  end
  // zeros frame the payload slot, dark line changes every cycle
  always_comb begin
    pidx = cnt - REFRESH_SYMS;
    rx_frame_sync = (cnt == SLOT - 1);
    rx_sym = {cnt[6:0], 1'b1};
    if (slp && cnt >= REFRESH_SYMS && (pidx < ZERO_SYMS || pidx >= ZERO_SYMS + QUIET)) begin
      rx_sym = 8'h00;
    end
  end
endmodule // plpic_link_partner
`default_nettype wire

// ---- sim/plpic_lpi_ctrl_bench.sv ----
// testbench for the pcs low power idle control block
`timescale 1ns/1ps
`default_nettype none
module plpic_lpi_ctrl_bench;
  import plpic_pkg::*;
  localparam int unsigned QUIET = 20;
  localparam int unsigned SLOT = REFRESH_SYMS + 2 * ZERO_SYMS + QUIET;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, sleep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tx_lpi_req, enc_blk_end, enc_blk_lpi, tx_pcs_on, rx_frame_sync, rx_blk_start;
  logic rx_blk_lpi, rx_lpi, rx_dec_en, rx_pcs_on, rx_adapt_en, rx_margin_en, rx_status_upd;
  logic [SYM_W-1:0] tx_sym_in, tx_sym_out, rx_sym;
  int miscompares, compares, n, q;
  plpic_lpi_ctrl #(.QUIET(QUIET)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_lpi_req(tx_lpi_req), .enc_blk_end(enc_blk_end),
    .enc_blk_lpi(enc_blk_lpi), .tx_sym_in(tx_sym_in), .tx_sym_out(tx_sym_out),
    .tx_pcs_on(tx_pcs_on), .rx_sym(rx_sym), .rx_frame_sync(rx_frame_sync),
    .rx_blk_start(rx_blk_start), .rx_blk_lpi(rx_blk_lpi), .rx_lpi(rx_lpi),
    .rx_dec_en(rx_dec_en), .rx_pcs_on(rx_pcs_on), .rx_adapt_en(rx_adapt_en),
    .rx_margin_en(rx_margin_en), .rx_status_upd(rx_status_upd));
  plpic_link_partner #(.QUIET(QUIET)) partner_u (.pclk(pclk), .presetn(presetn),
    .sleep(sleep), .rx_sym(rx_sym), .rx_frame_sync(rx_frame_sync));
  always #5 pclk = ~pclk;
  always @(posedge pclk) tx_sym_in <= tx_sym_in + 8'h01;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task complete_run;
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n == lim) chk("wait", v, s);
  endtask
  task automatic count_low(ref logic s);
    q = 0;
    while (s === 1'b0 && q < SLOT) begin
      @(posedge pclk);
      q++;
    end
  endtask
  task hold_on(input int c);
    logic b;
    b = 1'b0;
    repeat (c) begin
      @(posedge pclk);
      if (tx_pcs_on !== 1'b1) b = 1'b1;
    end
    chk("tx gate dropped", 0, b);
  endtask
  task pulse_blk;
    enc_blk_end <= 1'b1;
    enc_blk_lpi <= 1'b1;
    @(posedge pclk);
    enc_blk_end <= 1'b0;
    enc_blk_lpi <= 1'b0;
  endtask
  task t_regs_refused;
    chk("rx_dec_en", 1, rx_dec_en);
    apb(1'b0, OFF_CTRL, 0);
    chk("ctrl reset", 0, rd);
    apb(1'b0, 12'h00c, 0);
    chk("unmapped err", 1, err);
    tx_lpi_req <= 1'b1;
    pulse_blk();
    hold_on(2 * SLOT);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    apb(1'b0, OFF_CTRL, 0);
    chk("ctrl", 1, rd);
  endtask
  task t_tx;
    pulse_blk();
    wait_sig(tx_pcs_on, 1'b0, 2 * SLOT);
    count_low(tx_pcs_on);
    chk("tx quiet", QUIET, q);
    wait_sig(tx_pcs_on, 1'b0, SLOT);
    chk("tx slot", SLOT, q + n);
    apb(1'b0, OFF_STATUS, 0);
    chk("tx status", 3, rd[1:0]);
    tx_lpi_req <= 1'b0;
    count_low(tx_pcs_on);
    hold_on(SLOT);
    chk("tx data", tx_sym_in - 8'h01, tx_sym_out);
    apb(1'b0, OFF_COUNT, 0);
    chk("tx entries", 1, rd[15:0]);
  endtask
  task t_rx;
    sleep <= 1'b1;
    wait_sig(rx_lpi, 1'b1, 3 * SLOT);
    chk("rx_dec_en", 0, rx_dec_en);
    wait_sig(rx_pcs_on, 1'b0, SLOT);
    count_low(rx_pcs_on);
    chk("rx quiet", QUIET, q);
    wait_sig(rx_adapt_en, 1'b1, SLOT);
    chk("rx_margin_en", 1, rx_margin_en);
    apb(1'b0, OFF_STATUS, 0);
    chk("rx status", 1, rd[2]);
    sleep <= 1'b0;
    wait_sig(rx_status_upd, 1'b1, SLOT);
    repeat (40) @(posedge pclk);
    chk("rx_lpi waking", 1, rx_lpi);
    rx_blk_start <= 1'b1;
    @(posedge pclk);
    rx_blk_start <= 1'b0;
    @(posedge pclk);
    chk("rx_lpi", 0, rx_lpi);
    chk("rx_dec_en", 1, rx_dec_en);
    rx_blk_lpi <= 1'b1;
    @(posedge pclk);
    rx_blk_lpi <= 1'b0;
    @(posedge pclk);
    chk("rx block lpi", 1, rx_lpi);
    apb(1'b0, OFF_COUNT, 0);
    chk("rx entries", 1, rd[31:16]);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, tx_lpi_req, enc_blk_end, enc_blk_lpi} = '0;
    {rx_blk_start, rx_blk_lpi, sleep, paddr, pwdata} = '0;
    tx_sym_in = 8'h01;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs_refused();
    t_tx();
    t_rx();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    chk("watchdog", 0, 1);
    complete_run();
  end
endmodule // plpic_lpi_ctrl_bench
`default_nettype wire
